/* dv/control_source_select_test.sv */
// Testbench for the conditioning control source selector.
// Assumes APB answers without wait states and the SMBus host model.
`timescale 1ns/100ps
`include "css_consts.svh"
module control_source_select_test
   import css_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic mgmt_bus_select, scl, sda, sda_o, sda_oe, er;
   logic [3:0] slave_addr_strap;
   logic [1:0] eqa, eqb, output_swing, idle_thr_pin, idle_thr;
   logic [2:0] side_a_deemph, side_b_deemph, ack;
   logic rate_sel;
   lane_cfg_t [7:0] lane_cfg;
   int err_count = 0;
   int checked = 0;
   int cycles = 0;

   control_source_select control_source_select_i (.pclk(pclk),
      .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mgmt_bus_select(mgmt_bus_select), .scl(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .slave_addr_strap(slave_addr_strap), .side_a_eq_strap0(eqa[0]),
      .side_a_eq_strap1(eqa[1]), .side_b_eq_strap0(eqb[0]),
      .side_b_eq_strap1(eqb[1]), .side_a_deemph(side_a_deemph),
      .side_b_deemph(side_b_deemph), .output_swing(output_swing),
      .rate_sel(rate_sel), .idle_thr_pin(idle_thr_pin),
      .lane_cfg(lane_cfg), .idle_thr(idle_thr));
   smb_host smb_host_i (.pclk(pclk), .sda_o(sda_o), .sda_oe(sda_oe),
      .scl(scl), .sda(sda));

   ////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   // Entered right after a rising edge; request held until pready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge, so the next call never sets psel in this time step
      @(posedge pclk);
   endtask : apb
   task automatic pins(input logic [1:0] ea, eb);
      lane_cfg_t ca, cb;
      eqa <= ea;
      eqb <= eb;
      wt(5);
      ca = {rate_sel, output_swing, side_a_deemph, ea};
      cb = {rate_sel, output_swing, side_b_deemph, eb};
      for (int i = 0; i < 8; i++)
         chk("lane_cfg", lane_cfg[i], i < 4 ? ca : cb);
      chk("idle_thr", idle_thr, idle_thr_pin);
   endtask : pins

   ////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (sda_oe === 1'b1)
         chk("sda_o", sda_o, 1'b0);
      if (cycles == 20000) begin
         err_count++;
         wrap_up();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {mgmt_bus_select, eqa, eqb} = '0;
      slave_addr_strap = 4'ha;
      side_a_deemph = 3'h2;
      side_b_deemph = 3'h5;
      output_swing = 2'h1;
      rate_sel = 1'b1;
      idle_thr_pin = 2'h3;
      wt(2);
      presetn <= 1'b1;
      for (int e = 0; e < 4; e++)
         pins(e[1:0], 2'h3 - e[1:0]);
      apb(1'b0, `OFF_LANE0, 32'h0);
      chk("lane err", er, 1'b1);
      apb(1'b1, `OFF_IDLE, 32'h1);
      chk("idle err", er, 1'b1);
      apb(1'b0, `OFF_STAT, 32'h0);
      chk("stat", rd, {27'h0, slave_addr_strap, 1'b0});
      smb_host_i.xfer({`SLV_ADDR_HI, slave_addr_strap}, 8'h0, 8'h77, ack);
      chk("pin ack", ack, 3'h0);
      mgmt_bus_select <= 1'b1;
      wt(5);
      for (int i = 0; i < 8; i++)
         apb(1'b1, `OFF_LANE0 + 8'(4 * i), 32'(8'hc3 ^ 8'(37 * i)));
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, `OFF_LANE0 + 8'(4 * i), 32'h0);
         chk("lane rd", rd, 32'(8'hc3 ^ 8'(37 * i)));
         chk("lane_cfg", lane_cfg[i], 8'hc3 ^ 8'(37 * i));
      end
      apb(1'b0, 8'h28, 32'h0);
      chk("unmapped", er, 1'b1);
      apb(1'b1, `OFF_IDLE, 32'h2);
      apb(1'b0, `OFF_IDLE, 32'h0);
      chk("idle rd", rd, 32'h2);
      chk("idle reg", idle_thr, 2'h2);
      apb(1'b1, `OFF_STAT, 32'h0);
      chk("stat wr", er, 1'b1);
      eqa <= 2'h1;
      eqb <= 2'h2;
      wt(5);
      chk("eq ignored", lane_cfg[0], 8'hc3);
      chk("eq ignored", lane_cfg[4], 8'hc3 ^ 8'(37 * 4));
      smb_host_i.xfer({`SLV_ADDR_HI, slave_addr_strap}, 8'h3, 8'h6b, ack);
      chk("smb ack", ack, 3'h7);
      wt(5);
      chk("smb wr", lane_cfg[3], 8'h6b);
      smb_host_i.xfer({`SLV_ADDR_HI, 4'h5}, 8'h3, 8'h00, ack);
      chk("wrong addr", ack, 3'h0);
      chk("wrong addr", lane_cfg[3], 8'h6b);
      apb(1'b0, `OFF_STAT, 32'h0);
      chk("stat", rd, {27'h0, slave_addr_strap, 1'b1});
      mgmt_bus_select <= 1'b0;
      pins(2'h1, 2'h2);
      wrap_up();
   end
endmodule : control_source_select_test

/* dv/smb_host.sv */
// SMBus host model: drives SCL and pulls SDA low, never high.
// Assumes pclk is far faster than the bus and SDA has a pull-up.
`timescale 1ns/100ps
module smb_host (
   input wire logic pclk,
   input wire logic sda_o,
   input wire logic sda_oe,
   output logic scl,
   output logic sda
);
   localparam int Q = 6;
   logic pull_r = 1'b0;
   initial scl = 1'b1;
   // Pull-up wins unless some party pulls the wire low
   assign sda = ~pull_r & ~(sda_oe & ~sda_o);
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   // Data moves only with SCL low, a gap after the fall so the
   // synchronised view never sees a false start or stop
   task automatic put(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         wt(2);
         pull_r <= ~b[i];
         wt(Q);
         scl <= 1'b1;
         wt(Q);
         scl <= 1'b0;
      end
      wt(2);
      pull_r <= 1'b0;
      wt(Q);
      scl <= 1'b1;
      wt(Q);
      ack = ~sda;
      scl <= 1'b0;
   endtask : put
   task automatic xfer(input logic [6:0] a, input logic [7:0] p,
                       input logic [7:0] d, output logic [2:0] ack);
      pull_r <= 1'b1;
      wt(Q);
      scl <= 1'b0;
      wt(Q);
      put({a, 1'b0}, ack[2]);
      put(p, ack[1]);
      put(d, ack[0]);
      wt(2);
      pull_r <= 1'b1;
      wt(Q);
      scl <= 1'b1;
      wt(Q);
      pull_r <= 1'b0;
      wt(Q);
   endtask : xfer
endmodule : smb_host

/* hdl/control_source_select.sv */
// Conditioning control source selector: pin straps or SMBus registers.
// Assumes an APB master on pclk and an SMBus host far slower than pclk.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "css_consts.svh"
module control_source_select
   import css_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mgmt_bus_select,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic [3:0] slave_addr_strap,
   input wire logic side_a_eq_strap0,
   input wire logic side_a_eq_strap1,
   input wire logic side_b_eq_strap0,
   input wire logic side_b_eq_strap1,
   input wire logic [2:0] side_a_deemph,
   input wire logic [2:0] side_b_deemph,
   input wire logic [1:0] output_swing,
   input wire logic rate_sel,
   input wire logic [1:0] idle_thr_pin,
   output lane_cfg_t [7:0] lane_cfg,
   output logic [1:0] idle_thr
);

   typedef struct packed {
      smb_state_t fsm;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic [7:0] ptr;
      logic rw;
      logic nack;
      logic sda_oe;
      logic scl_d;
      logic sda_d;
      lane_cfg_t [7:0] regs;
      logic [1:0] idle_reg;
      lane_cfg_t [7:0] cfg_out;
      logic [1:0] idle_out;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } st_t;

   st_t r;
   st_t n;
   pins_t pins_raw;
   pins_t ps;
   lane_cfg_t [7:0] mux_cfg;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic [7:0] apb_idx;
   logic apb_ok;

   function automatic logic [7:0] reg_rd(input lane_cfg_t [7:0] regs,
                                         input logic [1:0] idl,
                                         input logic [7:0] idx);
      logic [7:0] v;
      v = 8'h00;
      if (idx < `IDX_IDLE) begin
         v = regs[idx[2:0]];
      end else if (idx == `IDX_IDLE) begin
         v = {6'h00, idl};
      end
      return v;
   endfunction : reg_rd

   //////////////////////////////////////////////////////////////////////
   // Pin capture and per-lane source selection

   assign pins_raw = '{mode: mgmt_bus_select, scl: scl, sda: sda_i,
                       addr: slave_addr_strap,
                       eq_a: {side_a_eq_strap1, side_a_eq_strap0},
                       eq_b: {side_b_eq_strap1, side_b_eq_strap0},
                       de_a: side_a_deemph, de_b: side_b_deemph,
                       swing: output_swing, rate: rate_sel,
                       idle: idle_thr_pin};

   pin_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pins_in(pins_raw),
      .pins_out(ps)
   );

   // Lanes 0-3 belong to side A, lanes 4-7 to side B
   for (genvar i = 0; i < `LANES; i++) begin : g_lane
      lane_mux u_mux (
         .mode(ps.mode),
         .eq_strap(i < `LANES_PER_SIDE ? ps.eq_a : ps.eq_b),
         .de_pin(i < `LANES_PER_SIDE ? ps.de_a : ps.de_b),
         .swing_pin(ps.swing),
         .rate_pin(ps.rate),
         .reg_cfg(r.regs[i]),
         .cfg(mux_cfg[i])
      );
   end

   //////////////////////////////////////////////////////////////////////
   // SMBus line events, seen only once both lines are synchronised

   assign rise = ps.scl & ~r.scl_d;
   assign fall = ~ps.scl & r.scl_d;
   assign start = ps.scl & r.scl_d & r.sda_d & ~ps.sda;
   assign stop = ps.scl & r.scl_d & ~r.sda_d & ps.sda;

   assign apb_idx = {4'h0, paddr[5:2]};
   assign apb_ok = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0) &&
                   (apb_idx <= `IDX_STAT);

   //////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      n = r;
      n.scl_d = ps.scl;
      n.sda_d = ps.sda;
      if (!ps.mode) begin
         // Bus logic held idle so no register can be reached
         n.fsm = S_IDLE;
         n.sda_oe = 1'b0;
         n.cnt = 4'h0;
      end else if (start) begin
         n.fsm = S_ADDR;
         n.cnt = 4'h0;
         n.sda_oe = 1'b0;
      end else if (stop) begin
         n.fsm = S_IDLE;
         n.sda_oe = 1'b0;
      end else if (rise) begin
         case (r.fsm)
            S_ADDR, S_PTR, S_WDATA: begin
               n.sh = {r.sh[6:0], ps.sda};
               n.cnt = 4'(r.cnt + 4'h1);
            end
            S_RDATA: begin
               n.cnt = 4'(r.cnt + 4'h1);
            end
            S_RACK: begin
               n.nack = ps.sda;
            end
            default: begin
            end
         endcase
      end else if (fall) begin
         // SDA only changes while SCL is low, so it never fakes a start
         case (r.fsm)
            S_ADDR: begin
               if (r.cnt == `BITS_PER_BYTE) begin
                  if (r.sh[7:1] == {`SLV_ADDR_HI, ps.addr}) begin
                     n.fsm = S_ACK_A;
                     n.rw = r.sh[0];
                     n.sda_oe = 1'b1;
                  end else begin
                     n.fsm = S_IDLE;
                  end
               end
            end
            S_ACK_A: begin
               n.cnt = 4'h0;
               if (r.rw) begin
                  n.tx = reg_rd(r.regs, r.idle_reg, r.ptr);
                  n.sda_oe = ~n.tx[7];
                  n.fsm = S_RDATA;
               end else begin
                  n.sda_oe = 1'b0;
                  n.fsm = S_PTR;
               end
            end
            S_PTR: begin
               if (r.cnt == `BITS_PER_BYTE) begin
                  n.ptr = r.sh;
                  n.sda_oe = 1'b1;
                  n.fsm = S_ACK_P;
               end
            end
            S_ACK_P, S_ACK_W: begin
               n.sda_oe = 1'b0;
               n.cnt = 4'h0;
               n.fsm = S_WDATA;
            end
            S_WDATA: begin
               if (r.cnt == `BITS_PER_BYTE) begin
                  if (r.ptr < `IDX_IDLE) begin
                     n.regs[r.ptr[2:0]] = lane_cfg_t'(r.sh);
                  end else if (r.ptr == `IDX_IDLE) begin
                     n.idle_reg = r.sh[1:0];
                  end
                  n.ptr = 8'(r.ptr + 8'h01);
                  n.sda_oe = 1'b1;
                  n.fsm = S_ACK_W;
               end
            end
            S_RDATA: begin
               if (r.cnt == `BITS_PER_BYTE) begin
                  n.sda_oe = 1'b0;
                  n.fsm = S_RACK;
               end else begin
                  n.tx = {r.tx[6:0], 1'b0};
                  n.sda_oe = ~n.tx[7];
               end
            end
            S_RACK: begin
               n.cnt = 4'h0;
               if (r.nack) begin
                  n.fsm = S_IDLE;
               end else begin
                  n.ptr = 8'(r.ptr + 8'h01);
                  n.tx = reg_rd(r.regs, r.idle_reg, n.ptr);
                  n.sda_oe = ~n.tx[7];
                  n.fsm = S_RDATA;
               end
            end
            default: begin
               n.fsm = S_IDLE;
            end
         endcase
      end

      // APB: answer is prepared in the setup cycle, so access is one cycle
      n.pready = 1'b0;
      if (psel && !penable && !r.pready) begin
         n.pready = 1'b1;
         n.prdata = 32'h0000_0000;
         n.pslverr = !apb_ok;
         if (apb_ok && apb_idx == `IDX_STAT) begin
            // Status is read-only in either mode
            n.pslverr = pwrite;
            n.prdata[`STAT_MODE] = ps.mode;
            n.prdata[`STAT_ADDR_LO +: 4] = ps.addr;
            n.prdata[`STAT_BUSY] = (r.fsm != S_IDLE);
         end else if (apb_ok && !ps.mode) begin
            n.pslverr = 1'b1;
         end else if (apb_ok && !pwrite) begin
            n.prdata[7:0] = reg_rd(r.regs, r.idle_reg, apb_idx);
         end else if (apb_ok && pwrite) begin
            n.pslverr = (apb_idx == `IDX_STAT);
         end
      end
      // Same-cycle APB write overrides an SMBus write to that register
      if (psel && penable && r.pready && pwrite && !r.pslverr) begin
         if (apb_idx < `IDX_IDLE) begin
            n.regs[apb_idx[2:0]] = lane_cfg_t'(pwdata[7:0]);
         end else if (apb_idx == `IDX_IDLE) begin
            n.idle_reg = pwdata[1:0];
         end
      end

      n.cfg_out = mux_cfg;
      n.idle_out = ps.mode ? r.idle_reg : ps.idle;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.fsm <= S_IDLE;
         r.scl_d <= 1'b1;
         r.sda_d <= 1'b1;
         r.regs <= {`LANES{`LANE_RST}};
         r.idle_reg <= `IDLE_RST;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign sda_oe = r.sda_oe;
   assign sda_o = 1'b0;
   assign lane_cfg = r.cfg_out;
   assign idle_thr = r.idle_out;

   //////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   blocked_write_a: assert property (
      psel && !penable && !r.pready && apb_ok && !ps.mode &&
      apb_idx != `IDX_STAT |=> pslverr && pready)
      else $error("register access not refused in pin mode");

   strap_eq_a: assert property (
      !ps.mode |=> lane_cfg[0].eq == $past(ps.eq_a) &&
                   lane_cfg[7].eq == $past(ps.eq_b))
      else $error("pin mode equalization not from straps");

   side_common_a: assert property (
      !ps.mode |=> lane_cfg[0] == lane_cfg[3] && lane_cfg[4] == lane_cfg[6])
      else $error("lanes of one side differ in pin mode");

   aux_pins_a: assert property (
      !ps.mode |=> idle_thr == $past(ps.idle) &&
                   lane_cfg[2].swing == $past(ps.swing) &&
                   lane_cfg[5].deemph == $past(ps.de_b))
      else $error("shared pins not steering conditioning");

   bus_off_a: assert property (
      !ps.mode |=> r.fsm == S_IDLE ##1 !sda_oe)
      else $error("SMBus active while select is low");

   drive_low_a: assert property (
      sda_oe |-> sda_o == 1'b0 &&
                 r.fsm inside {S_ACK_A, S_ACK_P, S_ACK_W, S_RDATA})
      else $error("SDA driven outside ack or read data");

   addr_miss_a: assert property (
      ps.mode && !start && !stop && fall && r.fsm == S_ADDR &&
      r.cnt == `BITS_PER_BYTE && r.sh[7:1] != {`SLV_ADDR_HI, ps.addr}
      |=> r.fsm == S_IDLE && !sda_oe)
      else $error("foreign address acknowledged");

   reg_lane_a: assert property (
      ps.mode && $stable(r.regs) |=> lane_cfg[5] == $past(r.regs[5]))
      else $error("register mode lane not from its register");

   apb_ready_a: assert property (
      psel && !penable && !pready |=> pready ##1 !pready)
      else $error("APB answer not one cycle after setup");

endmodule : control_source_select

/* hdl/lane_mux.sv */
// Chooses one lane's conditioning word from straps or its register.
// Assumes all inputs are already on pclk; purely combinational.
`timescale 1ns/100ps
module lane_mux
   import css_pkg::*;
(
   input wire logic mode,
   input wire logic [1:0] eq_strap,
   input wire logic [2:0] de_pin,
   input wire logic [1:0] swing_pin,
   input wire logic rate_pin,
   input wire lane_cfg_t reg_cfg,
   output lane_cfg_t cfg
);

   always_comb begin
      if (mode) begin
         cfg = reg_cfg;
      end else begin
         cfg.eq = eq_strap;
         cfg.deemph = de_pin;
         cfg.swing = swing_pin;
         cfg.rate = rate_pin;
      end
   end

endmodule : lane_mux

/* hdl/pin_sync.sv */
// Two-stage synchroniser for the strap, mode and SMBus pins.
// Assumes pins are asynchronous to pclk; only stage two is read.
`timescale 1ns/100ps
module pin_sync
   import css_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire pins_t pins_in,
   output pins_t pins_out
);

   typedef struct packed {
      pins_t meta;
      pins_t stable;
   } sync_st_t;

   sync_st_t r;
   sync_st_t n;

   always_comb begin
      n = r;
      n.meta = pins_in;
      n.stable = r.meta;
   end

   // SCL and SDA idle high, so their stages reset high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.meta.scl <= 1'b1;
         r.meta.sda <= 1'b1;
         r.stable.scl <= 1'b1;
         r.stable.sda <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign pins_out = r.stable;

endmodule : pin_sync

/* shared/css_consts.svh */
// Constants for the conditioning control source selector.
// Assumes byte offsets on a 32-bit APB slave and a 25 MHz pclk.
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH

`define LANES 8
`define LANES_PER_SIDE 4
`define BITS_PER_BYTE 4'h8
`define LANE_RST 8'h00
`define IDLE_RST 2'h0
// Fixed upper part of the SMBus slave address (value arbitrary)
`define SLV_ADDR_HI 3'h5
`define IDX_IDLE 8'h08
`define IDX_STAT 8'h09
`define OFF_LANE0 8'h00
`define OFF_IDLE 8'h20
`define OFF_STAT 8'h24
`define STAT_MODE 0
`define STAT_ADDR_LO 1
`define STAT_BUSY 5

`endif

/* shared/css_pkg.sv */
// Types shared by the conditioning control source selector.
// Assumes the constants header is included by the design files.
package css_pkg;

   // One lane's conditioning word, same layout as its register
   typedef struct packed {
      logic rate;
      logic [1:0] swing;
      logic [2:0] deemph;
      logic [1:0] eq;
   } lane_cfg_t;

   // All pins that cross into pclk, synchronised as one vector
   typedef struct packed {
      logic mode;
      logic scl;
      logic sda;
      logic [3:0] addr;
      logic [1:0] eq_a;
      logic [1:0] eq_b;
      logic [2:0] de_a;
      logic [2:0] de_b;
      logic [1:0] swing;
      logic rate;
      logic [1:0] idle;
   } pins_t;

   typedef enum logic [8:0] {
      S_IDLE  = 9'h001,
      S_ADDR  = 9'h002,
      S_ACK_A = 9'h004,
      S_PTR   = 9'h008,
      S_ACK_P = 9'h010,
      S_WDATA = 9'h020,
      S_ACK_W = 9'h040,
      S_RDATA = 9'h080,
      S_RACK  = 9'h100
   } smb_state_t;

endpackage : css_pkg
